// file: logic/mc_defs.svh
`ifndef MC_DEFS_SVH
`define MC_DEFS_SVH
// Register byte addresses
`define MC_SEG_DIST_BASE  16'h2500
`define MC_SEG_SPEED_BASE 16'h2510
`define MC_SEG_TYPE_BASE  16'h2520
`define MC_SEG_CHAIN_BASE 16'h2530
`define MC_TIMER_ADDR     16'h2900
`define MC_REQ_INPUT_ADDR 16'h2E00
`define MC_REQ_CODE_ADDR  16'h2E04
`define MC_REQ_DATA_ADDR  16'h2E08
`define MC_RPL_OUT_ADDR   16'h2E10
`define MC_RPL_CODE_ADDR  16'h2E14
`define MC_RPL_DATA_ADDR  16'h2E18
`define MC_CTRL_ADDR      16'h3000
`define MC_EXCITE_ADDR    16'h3004
`define MC_STATUS_ADDR    16'h3008
`define MC_IRQ_STAT_ADDR  16'h300C
`define MC_IRQ_MASK_ADDR  16'h3010
// Control field positions
`define MC_CTRL_START_LSB  0
`define MC_CTRL_IN_A_LSB 2
`define MC_CTRL_ALARM_ACT_BIT 4
`define MC_CTRL_SEQEND_BIT 5
`define MC_CTRL_ALMCLR_BIT 6
// Interrupt bit positions
`define MC_IRQ_SEQ_START 0
`define MC_IRQ_IN_A    1
`define MC_IRQ_ALARM     2
`define MC_IRQ_EXCITE    3
`define MC_IRQ_REQUEST   4
`define MC_IRQ_WIDTH     5
// Reset values, limits and setting codes
`define MC_SPEED_RESET   32'h0000_03E8
`define MC_TYPE_RESET    1'b1
`define MC_CHAIN_RESET   1'b0
`define MC_TIMER_MAX     32'h1DCD_6500
`define MC_IN_A_HOME_ONLY 2'h3
`define MC_START_RESUMES 2'h0
// Timing
`define MC_CLK_HZ        40000000
`define MC_MS_PER_SEC    1000
`define MC_RUN_MAX_MS    2
`define MC_ALARM_MAX_MS  5
`define MC_MS_CYCLES     (`MC_CLK_HZ / `MC_MS_PER_SEC)
`endif

// file: logic/mc_pkg.sv
`default_nettype none
package mc_pkg;
  typedef enum logic [2:0] {
    MC_IDLE  = 3'b001,
    MC_RUN   = 3'b010,
    MC_PAUSE = 3'b100
  } mc_seq_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } mc_bus_req_t;

  typedef struct packed {
    logic [8:0] general_inputs;
    logic       start;
    logic       abort;
    logic       pause;
    logic       continue_in;
    logic       in_a;
    logic       alarm;
    logic       excite_line;
  } mc_pins_t;

  typedef struct packed {
    logic [15:0] input_word;
    logic [15:0] code;
    logic [31:0] payload;
  } mc_msg_t;
endpackage
`default_nettype wire

// file: logic/mc_link_io.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "mc_defs.svh"
module mc_link_io #(
  parameter int unsigned MS_CYCLES      = `MC_MS_CYCLES,
  parameter logic [31:0] POSITION_LIMIT = 32'h1DCD_6500,
  parameter logic [31:0] SPEED_LIMIT    = 32'h1DCD_6500
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Register port
  input  wire mc_pkg::mc_bus_req_t bus,
  output logic [31:0]           rdata,
  // Discrete pins
  input  wire mc_pkg::mc_pins_t pins,
  output logic                  run_out,
  output logic                  paused_out,
  output logic                  alarm_out,
  output logic                  excite_out,
  output logic                  brake_release_out,
  output logic                  in_a_stop,
  output logic [8:0]            seq_number,
  // Request and reply exchange
  output mc_pkg::mc_msg_t       request,
  output logic                  request_strobe,
  input  wire mc_pkg::mc_msg_t  reply,
  input  wire logic             reply_load,
  // Interrupt
  output logic                  irq
);
  import mc_pkg::*;

  localparam int PW = $bits(mc_pins_t);

  logic                      rst_s1;
  logic                      rst_n;
  logic [PW-1:0]             sync1;
  logic [PW-1:0]             sync2;
  logic [PW-1:0]             sync3;
  mc_pins_t                  lvl;
  mc_pins_t                  rise;
  mc_pins_t                  fall;
  logic signed [31:0]        seg_target_value [4];
  logic [31:0]               seg_speed_value [4];
  logic [3:0]                seg_move_type;
  logic [2:0]                seg_chain_flag;
  logic [31:0]               timer_ms;
  logic [31:0]               ms_div;
  logic [1:0]                start_action_setting;
  logic [1:0]                in_a_action_setting;
  logic                      alarm_action_setting;
  logic                      excite_cmd;
  logic [`MC_IRQ_WIDTH-1:0]  irq_stat;
  logic [`MC_IRQ_WIDTH-1:0]  irq_mask;
  logic [`MC_IRQ_WIDTH-1:0]  irq_event;
  mc_msg_t                   reply_area;
  mc_seq_state_t             state;
  mc_seq_state_t             next_state;
  logic                      wr_ctrl;
  logic                      seq_end_req;
  logic                      alarm_clr_req;
  logic                      resume;
  logic                      in_a_hit;
  logic signed [31:0]        wdata_s;
  logic [31:0]               next_rdata;

  // Reset release through two flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  assign lvl  = mc_pins_t'(sync2);
  assign rise = mc_pins_t'(sync2 & ~sync3);
  assign fall = mc_pins_t'(~sync2 & sync3);

  assign wdata_s       = $signed(bus.wdata);
  assign wr_ctrl       = bus.wr && bus.addr == `MC_CTRL_ADDR;
  assign seq_end_req   = wr_ctrl && bus.wdata[`MC_CTRL_SEQEND_BIT];
  assign alarm_clr_req = wr_ctrl && bus.wdata[`MC_CTRL_ALMCLR_BIT];

  // Segment table; out-of-range writes are clamped, not refused
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        seg_target_value[i] <= '0;
        seg_speed_value[i]  <= `MC_SPEED_RESET;
      end
      seg_move_type  <= {4{`MC_TYPE_RESET}};
      seg_chain_flag <= {3{`MC_CHAIN_RESET}};
    end else if (bus.wr) begin
      for (int i = 0; i < 4; i++) begin
        if (bus.addr == `MC_SEG_DIST_BASE + 16'(4 * i)) begin
          if (wdata_s > $signed(POSITION_LIMIT))
            seg_target_value[i] <= $signed(POSITION_LIMIT);
          else if (wdata_s < -$signed(POSITION_LIMIT))
            seg_target_value[i] <= -$signed(POSITION_LIMIT);
          else
            seg_target_value[i] <= wdata_s;
        end
        if (bus.addr == `MC_SEG_SPEED_BASE + 16'(4 * i)) begin
          if (wdata_s < 32'sd1)
            seg_speed_value[i] <= 32'h0000_0001;
          else if (bus.wdata > SPEED_LIMIT)
            seg_speed_value[i] <= SPEED_LIMIT;
          else
            seg_speed_value[i] <= bus.wdata;
        end
        if (bus.addr == `MC_SEG_TYPE_BASE + 16'(4 * i))
          seg_move_type[i] <= bus.wdata[0];
        if (i < 3 && bus.addr == `MC_SEG_CHAIN_BASE + 16'(4 * i))
          seg_chain_flag[i] <= bus.wdata[0];
      end
    end
  end

  // Millisecond timer, write wins over tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_div   <= '0;
      timer_ms <= '0;
    end else begin
      ms_div <= (ms_div == 32'(MS_CYCLES - 1)) ? '0 : ms_div + 32'h1;
      if (bus.wr && bus.addr == `MC_TIMER_ADDR)
        timer_ms <= (bus.wdata > `MC_TIMER_MAX) ? `MC_TIMER_MAX : bus.wdata;
      else if (ms_div == 32'(MS_CYCLES - 1))
        timer_ms <= (timer_ms >= `MC_TIMER_MAX) ? '0 : timer_ms + 32'h1;
    end
  end

  // Settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_action_setting  <= '0;
      in_a_action_setting <= '0;
      alarm_action_setting  <= 1'b0;
    end else if (wr_ctrl) begin
      start_action_setting  <= bus.wdata[`MC_CTRL_START_LSB +: 2];
      in_a_action_setting <= bus.wdata[`MC_CTRL_IN_A_LSB +: 2];
      alarm_action_setting  <= bus.wdata[`MC_CTRL_ALARM_ACT_BIT];
    end
  end

  assign resume = rise.continue_in ||
                  (rise.start && start_action_setting == `MC_START_RESUMES);
  // Setting 3 keeps in_a for homing only
  assign in_a_hit = rise.in_a && in_a_action_setting != `MC_IN_A_HOME_ONLY;

  // Sequence state
  always_comb begin
    next_state = state;
    case (state)
      MC_IDLE: begin
        if (rise.start && !alarm_out)
          next_state = MC_RUN;
      end
      MC_RUN: begin
        if (rise.abort || seq_end_req || in_a_hit || alarm_out)
          next_state = MC_IDLE;
        else if (rise.pause)
          next_state = MC_PAUSE;
      end
      MC_PAUSE: begin
        if (rise.abort || seq_end_req || alarm_out)
          next_state = MC_IDLE;
        else if (resume)
          next_state = MC_RUN;
      end
      default: next_state = MC_IDLE;
    endcase
  end

  // Running output rises the cycle after the synchronised start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state      <= MC_IDLE;
      seq_number <= '0;
    end else begin
      state <= next_state;
      // Host holds the number stable 2 ms ahead of start
      if (state == MC_IDLE && rise.start)
        seq_number <= lvl.general_inputs;
    end
  end
  assign run_out    = state != MC_IDLE;
  assign paused_out = state == MC_PAUSE;

  // In_a stop pulse
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      in_a_stop <= 1'b0;
    else
      in_a_stop <= in_a_hit && state == MC_RUN;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      alarm_out <= 1'b0;
    else if (rise.alarm)
      alarm_out <= 1'b1;
    else if (alarm_clr_req && !lvl.alarm)
      alarm_out <= 1'b0;
  end

  // Excitation command; line edges win over software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      excite_cmd <= 1'b0;
    else if (fall.excite_line && excite_cmd)
      excite_cmd <= 1'b0;
    else if (rise.excite_line && !excite_cmd)
      excite_cmd <= 1'b1;
    // Alarm with current-off action drops current
    else if (rise.alarm && !alarm_action_setting)
      excite_cmd <= 1'b0;
    // Writes honoured only while line high
    else if (bus.wr && bus.addr == `MC_EXCITE_ADDR && lvl.excite_line)
      excite_cmd <= bus.wdata[0];
  end
  assign excite_out        = excite_cmd;
  assign brake_release_out = excite_cmd;

  // Request and reply areas
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request        <= '0;
      request_strobe <= 1'b0;
      reply_area     <= '0;
    end else begin
      request_strobe <= bus.wr && bus.addr == `MC_REQ_DATA_ADDR;
      if (bus.wr && bus.addr == `MC_REQ_INPUT_ADDR)
        request.input_word <= bus.wdata[15:0];
      if (bus.wr && bus.addr == `MC_REQ_CODE_ADDR)
        request.code <= bus.wdata[15:0];
      if (bus.wr && bus.addr == `MC_REQ_DATA_ADDR)
        request.payload <= bus.wdata;
      if (reply_load)
        reply_area <= reply;
    end
  end

  // Interrupts: set wins over write-one-to-clear
  assign irq_event = {request_strobe, rise.excite_line || fall.excite_line,
                      rise.alarm, in_a_stop, state == MC_IDLE && next_state == MC_RUN};
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else begin
      if (bus.wr && bus.addr == `MC_IRQ_STAT_ADDR)
        irq_stat <= (irq_stat & ~bus.wdata[`MC_IRQ_WIDTH-1:0]) | irq_event;
      else
        irq_stat <= irq_stat | irq_event;
      if (bus.wr && bus.addr == `MC_IRQ_MASK_ADDR)
        irq_mask <= bus.wdata[`MC_IRQ_WIDTH-1:0];
    end
  end
  assign irq = |(irq_stat & irq_mask);

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdata = '0;
    for (int i = 0; i < 4; i++) begin
      if (bus.addr == `MC_SEG_DIST_BASE + 16'(4 * i))
        next_rdata = seg_target_value[i];
      if (bus.addr == `MC_SEG_SPEED_BASE + 16'(4 * i))
        next_rdata = seg_speed_value[i];
      if (bus.addr == `MC_SEG_TYPE_BASE + 16'(4 * i))
        next_rdata = {31'h0, seg_move_type[i]};
      if (i < 3 && bus.addr == `MC_SEG_CHAIN_BASE + 16'(4 * i))
        next_rdata = {31'h0, seg_chain_flag[i]};
    end
    case (bus.addr)
      `MC_TIMER_ADDR:     next_rdata = timer_ms;
      `MC_REQ_INPUT_ADDR: next_rdata = {16'h0, request.input_word};
      `MC_REQ_CODE_ADDR:  next_rdata = {16'h0, request.code};
      `MC_REQ_DATA_ADDR:  next_rdata = request.payload;
      `MC_RPL_OUT_ADDR:   next_rdata = {16'h0, reply_area.input_word};
      `MC_RPL_CODE_ADDR:  next_rdata = {16'h0, reply_area.code};
      `MC_RPL_DATA_ADDR:  next_rdata = reply_area.payload;
      `MC_CTRL_ADDR:      next_rdata = {27'h0, alarm_action_setting,
                                        in_a_action_setting, start_action_setting};
      `MC_EXCITE_ADDR:    next_rdata = {31'h0, excite_cmd};
      `MC_STATUS_ADDR:    next_rdata = {19'h0, seq_number, lvl.excite_line,
                                        alarm_out, paused_out, run_out};
      `MC_IRQ_STAT_ADDR:  next_rdata = {27'h0, irq_stat};
      `MC_IRQ_MASK_ADDR:  next_rdata = {27'h0, irq_mask};
      default: begin
      end
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata <= '0;
    else
      rdata <= bus.rd ? next_rdata : '0;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_start_runs: assert property (
    state == MC_IDLE && rise.start && !alarm_out |=> run_out)
    else $error("running output not raised after start");
  a_continue_resume: assert property (
    paused_out && rise.continue_in && !rise.abort && !seq_end_req && !alarm_out
    |=> run_out && !paused_out)
    else $error("continue did not resume");
  a_start_noresume: assert property (
    paused_out && start_action_setting != 2'h0 && !rise.continue_in |=> paused_out || !run_out)
    else $error("start resumed with start action nonzero");
  a_in_a_home: assert property (
    in_a_action_setting == 2'h3 |=> !in_a_stop)
    else $error("in_a stopped motor in homing-only mode");
  a_alarm_fast: assert property (
    $rose(pins.alarm) |-> ##[1:4] alarm_out)
    else $error("alarm output late");
  a_excite_fall: assert property (
    fall.excite_line && excite_cmd |=> !excite_out && !brake_release_out)
    else $error("excitation not dropped on falling line");
  a_excite_ro: assert property (
    !lvl.excite_line && !rise.excite_line && !fall.excite_line && !rise.alarm
    |=> $stable(excite_cmd))
    else $error("excite command changed while line low");
  a_excite_rise: assert property (
    rise.excite_line && !excite_cmd |=> excite_out && brake_release_out)
    else $error("excitation not raised on rising line");
  a_excite_write: assert property (
    bus.wr && bus.addr == 16'h3004 && lvl.excite_line && !rise.alarm
    && !fall.excite_line && !rise.excite_line |=> excite_out == $past(bus.wdata[0]))
    else $error("excite write not applied");
  a_one_edge: assert property (
    $rose(pins.start) |-> ##2 rise.start ##1 !rise.start)
    else $error("one edge gave two start pulses");
  a_speed_range: assert property (
    seg_speed_value[0] >= 32'h1 && seg_speed_value[0] <= SPEED_LIMIT)
    else $error("speed outside range");
  a_timer_range: assert property (
    timer_ms <= 32'h1DCD_6500)
    else $error("timer above maximum");
  a_target_range: assert property (
    seg_target_value[1] <= $signed(POSITION_LIMIT))
    else $error("target above limit");
  a_type_write: assert property (
    bus.wr && bus.addr == 16'h2520 |=> seg_move_type[0] == $past(bus.wdata[0]))
    else $error("move type not written");
  a_chain_write: assert property (
    bus.wr && bus.addr == 16'h2538 |=> seg_chain_flag[2] == $past(bus.wdata[0]))
    else $error("chain flag not written");

  c_run_pause: cover property (run_out ##1 paused_out ##[1:50] !paused_out && run_out);
  c_alarm: cover property (rise.alarm ##[1:3] alarm_out);
  c_excite: cover property (rise.excite_line ##[1:200] fall.excite_line);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire

// file: tb/mc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mc_host_model #(
  parameter int MS = 4
) (
  // Clock
  input  wire logic            clk,
  // Discrete lines toward the device
  output var mc_pkg::mc_pins_t pins,
  // Request and reply exchange
  input  wire mc_pkg::mc_msg_t request,
  input  wire logic            request_strobe,
  output var mc_pkg::mc_msg_t  reply,
  output var logic             reply_load
);
  import mc_pkg::*;
  initial begin
    pins = '0;
    reply = '0;
    reply_load = 1'b0;
  end
  task automatic present(input logic [8:0] num);
    @(posedge clk);
    pins.general_inputs <= num;
    repeat (2 * MS) @(posedge clk);
  endtask
  // Held six cycles so the synchroniser sees it
  task automatic drive_pin(input int idx, input logic v);
    @(posedge clk);
    pins[idx] <= v;
    repeat (6) @(posedge clk);
  endtask
  task automatic pulse(input int idx);
    drive_pin(idx, 1'b1);
    drive_pin(idx, 1'b0);
  endtask
  // Released reply bus shows inverted data, not the last value
  always @(posedge clk) begin
    reply_load <= request_strobe;
    if (request_strobe) begin
      reply <= {request.input_word, request.code, ~request.payload};
    end else if (reply_load) begin
      reply <= ~reply;
    end
  end
endmodule
`default_nettype wire

// file: tb/motion_io_and_link_objects_bench.sv
`timescale 1ns/1ps
`default_nettype none
module motion_io_and_link_objects_bench;
  import mc_pkg::*;
  localparam int MS = 4;
  localparam int LIMIT = 20000;
  localparam int P_EXC = 0;
  localparam int P_ALM = 1;
  localparam int P_SNS = 2;
  localparam int P_RESUME = 3;
  localparam int P_PAUSE = 4;
  localparam int P_START = 6;
  logic        clk;
  logic        resetn;
  mc_bus_req_t bus;
  logic [31:0] rdata;
  mc_pins_t    pins;
  logic        run_out;
  logic        paused_out;
  logic        alarm_out;
  logic        excite_out;
  logic        brake_release_out;
  logic        irq;
  logic [8:0]  seq_number;
  logic        in_a_stop;
  int          stops = 0;
  mc_msg_t     request;
  logic        request_strobe;
  mc_msg_t     reply;
  logic        reply_load;
  logic [5:0]  outs;
  int          num_errors = 0;
  int          checks = 0;
  int          cycles = 0;
  assign outs = {irq, brake_release_out, excite_out, alarm_out, paused_out, run_out};
  mc_link_io #(
    .MS_CYCLES      (MS),
    .POSITION_LIMIT (32'h0000_1000),
    .SPEED_LIMIT    (32'h0000_2000)
  ) i_dut (
    .clk               (clk),
    .resetn            (resetn),
    .bus               (bus),
    .rdata             (rdata),
    .pins              (pins),
    .run_out           (run_out),
    .paused_out        (paused_out),
    .alarm_out         (alarm_out),
    .excite_out        (excite_out),
    .brake_release_out (brake_release_out),
    .in_a_stop       (in_a_stop),
    .seq_number        (seq_number),
    .request           (request),
    .request_strobe    (request_strobe),
    .reply             (reply),
    .reply_load        (reply_load),
    .irq               (irq)
  );
  mc_host_model #(
    .MS (MS)
  ) i_host (
    .clk            (clk),
    .pins           (pins),
    .request        (request),
    .request_strobe (request_strobe),
    .reply          (reply),
    .reply_load     (reply_load)
  );
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  // Stop pulse lasts one cycle; counted mid-cycle where it is settled
  always @(negedge clk) begin
    if (in_a_stop === 1'b1)
      stops <= stops + 1;
  end
  task automatic close_out();
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      close_out();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    v = rdata;
  endtask
  task automatic rc(input string what, input logic [15:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    check(what, v, e);
  endtask
  task automatic lv(input logic [5:0] e);
    #1;
    check("levels", {26'h0, outs}, {26'h0, e});
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++) begin
      rc("target", 16'h2500 + 16'(4 * i), 32'h0);
      rc("speed", 16'h2510 + 16'(4 * i), 32'h0000_03E8);
      rc("type", 16'h2520 + 16'(4 * i), 32'h1);
      rc("chain", 16'h2530 + 16'(4 * i), 32'h0);
      wr(16'h2520 + 16'(4 * i), 32'h0);
      wr(16'h2530 + 16'(4 * i), 32'h1);
    end
    for (int i = 0; i < 4; i++) begin
      rc("type", 16'h2520 + 16'(4 * i), 32'h0);
      rc("chain", 16'h2530 + 16'(4 * i), {31'h0, i < 3});
    end
    rc("unmapped", 16'h2F00, 32'h0);
    lv(6'b000000);
  endtask
  task automatic t_clamp();
    logic [15:0] a[6] = '{16'h2500, 16'h2504, 16'h2508, 16'h2510, 16'h2514, 16'h2518};
    logic [31:0] w[6] = '{32'h0000_5000, 32'hFFFF_B000, 32'hFFFF_FFFE,
                          32'h0, 32'h0000_3000, 32'h0000_2000};
    logic [31:0] e[6] = '{32'h0000_1000, 32'hFFFF_F000, 32'hFFFF_FFFE,
                          32'h1, 32'h0000_2000, 32'h0000_2000};
    for (int i = 0; i < 6; i++) begin
      wr(a[i], w[i]);
      rc("clamped", a[i], e[i]);
    end
  endtask
  task automatic t_timer();
    logic [31:0] v;
    wr(16'h2900, 32'h64);
    repeat (10 * MS) @(posedge clk);
    rd(16'h2900, v);
    check("timer", {31'h0, v >= 32'h6E && v <= 32'h70}, 32'h1);
    wr(16'h2900, 32'hFFFF_FFFF);
    rd(16'h2900, v);
    check("timer top", {31'h0, v == 32'h1DCD_6500 || v == 32'h0}, 32'h1);
  endtask
  task automatic t_exchange();
    wr(16'h2E00, 32'h0000_1234);
    wr(16'h2E04, 32'h0000_0056);
    wr(16'h2E08, 32'hA5A5_0F0F);
    repeat (4) @(posedge clk);
    wr(16'h2E18, 32'h0);
    rc("reply word", 16'h2E10, 32'h0000_1234);
    rc("reply code", 16'h2E14, 32'h0000_0056);
    rc("reply data", 16'h2E18, 32'h5A5A_F0F0);
    rc("request", 16'h2E08, 32'hA5A5_0F0F);
  endtask
  task automatic t_seq();
    i_host.present(9'h15A);
    i_host.drive_pin(P_START, 1'b1);
    lv(6'b000001);
    i_host.drive_pin(P_START, 1'b0);
    check("number", {23'h0, seq_number}, 32'h15A);
    rc("status", 16'h3008, 32'h0000_15A1);
    wr(16'h3010, 32'h1);
    lv(6'b100001);
    wr(16'h300C, 32'h1);
    lv(6'b000001);
    wr(16'h3010, 32'h0);
  endtask
  task automatic t_pause();
    i_host.pulse(P_PAUSE);
    lv(6'b000011);
    i_host.pulse(P_START);
    lv(6'b000001);
    wr(16'h3000, 32'h1);
    i_host.pulse(P_PAUSE);
    i_host.pulse(P_START);
    lv(6'b000011);
    i_host.pulse(P_RESUME);
    lv(6'b000001);
    wr(16'h3000, 32'h0);
  endtask
  task automatic t_in_a();
    wr(16'h3000, 32'hC);
    i_host.pulse(P_SNS);
    lv(6'b000001);
    check("in_a stops", stops, 32'h0);
    wr(16'h3000, 32'h0);
    i_host.pulse(P_SNS);
    lv(6'b000000);
    check("in_a stops", stops, 32'h1);
    rc("irq status", 16'h300C, 32'h0000_0012);
  endtask
  task automatic t_excite();
    i_host.drive_pin(P_EXC, 1'b1);
    lv(6'b011000);
    rc("excite cmd", 16'h3004, 32'h1);
    wr(16'h3004, 32'h0);
    lv(6'b000000);
    repeat (8) @(posedge clk);
    lv(6'b000000);
    wr(16'h3004, 32'h1);
    lv(6'b011000);
    i_host.drive_pin(P_EXC, 1'b0);
    lv(6'b000000);
    wr(16'h3004, 32'h1);
    rc("excite cmd", 16'h3004, 32'h0);
    lv(6'b000000);
    i_host.drive_pin(P_EXC, 1'b1);
  endtask
  task automatic t_alarm();
    i_host.present(9'h0A5);
    i_host.pulse(P_START);
    lv(6'b011001);
    check("number", {23'h0, seq_number}, 32'h0A5);
    i_host.drive_pin(P_ALM, 1'b1);
    lv(6'b000100);
    i_host.drive_pin(P_ALM, 1'b0);
    wr(16'h3000, 32'h40);
    lv(6'b000000);
    wr(16'h3004, 32'h1);
    wr(16'h3000, 32'h10);
    i_host.drive_pin(P_ALM, 1'b1);
    lv(6'b011100);
    i_host.drive_pin(P_ALM, 1'b0);
    wr(16'h3000, 32'h50);
    lv(6'b011000);
  endtask
  initial begin
    resetn = 1'b0;
    bus = '0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_clamp();
    t_timer();
    t_exchange();
    t_seq();
    t_pause();
    t_in_a();
    t_excite();
    t_alarm();
    close_out();
  end
endmodule
`default_nettype wire
